// ---- tb/lce_mem_model.sv ----
// Behavioural program memory and bit area on the evaluator's far side.
`timescale 1ns/100ps
`include "lce_defs.svh"

module lce_mem_model
    import lce_pkg::*;
(
    input wire logic mclk,
    input wire logic [`LCE_PA_W-1:0] progAddr,
    input wire logic progRdEn,
    output logic [`LCE_INSTR_W-1:0] progData,
    input wire logic [`LCE_BA_W-1:0] bitAddr,
    input wire logic bitRdEn,
    output logic bitRdData,
    input wire logic bitWrEn,
    input wire logic bitWrData
);
    // ********************
    // Storage and access
    // ********************
    logic [`LCE_INSTR_W-1:0] prog [0:1023];
    logic [255:0] bits;

    // Word arrives one cycle after the read; otherwise the bus shows junk.
    always @(posedge mclk)
    begin
        if (progRdEn)
            progData <= prog[progAddr];
        else
            progData <= ~prog[progAddr];
    end

    // Only 256 bits are modelled, so high address bits alias.
    assign bitRdData = bitRdEn ? bits[bitAddr[7:0]] : ~bits[bitAddr[7:0]];

    // Output instructions land in the bit area at the clock edge.
    always @(posedge mclk)
    begin
        if (bitWrEn)
            bits[bitAddr[7:0]] <= bitWrData;
    end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the ladder condition evaluator.
`timescale 1ns/100ps
`include "lce_defs.svh"

module tb
    import lce_pkg::*;
;
    // ********************
    // Signals and instances
    // ********************
    localparam logic [7:0] BITV = 8'ha6;
    logic mclk;
    logic rst;
    logic progReload;
    logic [`LCE_PA_W-1:0] progAddr;
    logic progRdEn;
    logic [`LCE_INSTR_W-1:0] progData;
    logic [`LCE_BA_W-1:0] bitAddr;
    logic bitRdEn;
    logic bitRdData;
    logic bitWrEn;
    logic bitWrData;
    logic execCond;
    logic scanDone;
    logic running;
    logic noEndError;
    logic underflowError;
    logic overflowError;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    int wrCount = 0;

    lce_evaluator dut_u (.mclk(mclk), .rst(rst), .progReload(progReload),
        .progAddr(progAddr), .progRdEn(progRdEn), .progData(progData),
        .bitAddr(bitAddr), .bitRdEn(bitRdEn), .bitRdData(bitRdData),
        .bitWrEn(bitWrEn), .bitWrData(bitWrData), .execCond(execCond),
        .scanDone(scanDone), .running(running), .noEndError(noEndError),
        .underflowError(underflowError), .overflowError(overflowError));

    lce_mem_model mem_u (.mclk(mclk), .progAddr(progAddr),
        .progRdEn(progRdEn), .progData(progData), .bitAddr(bitAddr),
        .bitRdEn(bitRdEn), .bitRdData(bitRdData), .bitWrEn(bitWrEn),
        .bitWrData(bitWrData));

    // Clock at 40 MHz.
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    // Cycle ceiling cuts a hang short; writes are counted for idle checks.
    always @(posedge mclk)
    begin
        cycles++;
        if (bitWrEn === 1'b1)
            wrCount++;
        if (cycles == 10000)
        begin
            fails++;
            end_sim();
        end
    end

    // ********************
    // Shared tasks
    // ********************
    task automatic chk(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input int i, input lce_op_type op, input int a);
        mem_u.prog[i] = {op, 16'(a)};
    endtask

    // Holding reload keeps the core quiet while memory is rewritten.
    task automatic start();
        @(negedge mclk);
        progReload = 1'b1;
        repeat (2) @(negedge mclk);
        for (int i = 0; i < 1024; i++)
            mem_u.prog[i] = {OP_NOP, 16'h0000};
        mem_u.bits = 256'(BITV);
    endtask

    task automatic run(input int n);
        int seen;
        seen = 0;
        progReload = 1'b0;
        for (int c = 0; c < 3000 && seen < n; c++)
        begin
            @(negedge mclk);
            if (scanDone === 1'b1)
                seen++;
        end
        chk(seen == n, 1'b1);
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic t_basic();
        lce_op_type op [0:16] = '{OP_LOAD, OP_AND_INV, OP_AND, OP_OR_INV,
            OP_OUT, OP_OUT_INV, OP_LOAD_INV, OP_OR, OP_OUT, OP_LOAD_INV,
            OP_OR, OP_OUT, OP_LOAD, OP_END, OP_LOAD_INV, OP_OUT, OP_END};
        int ad [0:16] = '{1, 3, 0, 4, 16, 17, 2, 6, 18, 6, 7, 19, 0, 5, 0,
            20, 0};
        start();
        for (int i = 0; i < 17; i++)
            wr(i, op[i], ad[i]);
        mem_u.bits[17] = 1'b1;
        mem_u.bits[18] = 1'b1;
        run(2);
        chk(mem_u.bits[16], 1'b1);
        chk(mem_u.bits[17], 1'b0);
        chk(mem_u.bits[18], 1'b0);
        chk(mem_u.bits[19], 1'b1);
        chk(mem_u.bits[20], 1'b0);
        chk(execCond, 1'b0);
        chk(running, 1'b1);
    endtask

    task automatic t_blocks();
        int ad [0:7] = '{1, 2, 5, 7, 1, 2, 0, 3};
        int ia [0:10] = '{5, 7, 1, 2, 0, 3, 1, 6, 5, 4, 7};
        logic e;
        start();
        // Deferred groups hold eight blocks, never more pending.
        for (int g = 0; g < 2; g++)
        begin
            for (int k = 0; k < 8; k++)
                wr(g * 16 + k, OP_LOAD, (g == 1 && k == 0) ? 0 : ad[k]);
            for (int k = 8; k < 15; k++)
                wr(g * 16 + k, (k < 14) ? OP_AND_BLK : OP_OR_BLK, 1);
            wr(g * 16 + 15, OP_OUT, 16 + g);
        end
        // Twelve blocks combined one at a time after the deferred groups.
        wr(32, OP_LOAD, 2);
        e = BITV[2];
        for (int k = 0; k < 11; k++)
        begin
            wr(33 + 2 * k, OP_LOAD, ia[k]);
            wr(34 + 2 * k, (k % 2 == 0 && k > 5) ? OP_OR_BLK : OP_AND_BLK, 0);
            e = (k % 2 == 0 && k > 5) ? (e | BITV[ia[k]]) : (e & BITV[ia[k]]);
        end
        wr(55, OP_OUT, 18);
        wr(56, OP_END, 0);
        mem_u.bits[17] = 1'b1;
        mem_u.bits[18] = !e;
        run(2);
        chk(mem_u.bits[16], 1'b1);
        chk(mem_u.bits[17], 1'b0);
        chk(mem_u.bits[18], e);
        chk(execCond, e);
        chk(overflowError, 1'b0);
        chk(underflowError, 1'b0);
    endtask

    // A first load never saves, so the combine finds the buffer empty.
    task automatic t_under();
        start();
        wr(0, OP_LOAD, 1);
        wr(1, OP_AND_BLK, 0);
        wr(2, OP_OUT, 21);
        wr(3, OP_END, 0);
        run(2);
        chk(underflowError, 1'b1);
        chk(overflowError, 1'b0);
        chk(mem_u.bits[21], 1'b1);
        chk(execCond, 1'b1);
    endtask

    task automatic t_over(input int n);
        start();
        for (int k = 0; k < n; k++)
            wr(k, OP_LOAD, k);
        wr(n, OP_END, 0);
        run(2);
        chk(overflowError, n > 9);
        chk(underflowError, 1'b0);
    endtask

    // Every word is an output; none may run without an end instruction.
    task automatic t_noend();
        start();
        for (int i = 0; i < 1024; i++)
            wr(i, OP_OUT, 22);
        wrCount = 0;
        progReload = 1'b0;
        repeat (2100) @(negedge mclk);
        chk(noEndError, 1'b1);
        chk(running, 1'b0);
        chk(progRdEn, 1'b0);
        chk(wrCount == 0, 1'b1);
    endtask

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        rst = 1'b1;
        progReload = 1'b1;
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        t_basic();
        t_blocks();
        t_under();
        t_over(9);
        t_over(10);
        t_noend();
        end_sim();
    end
endmodule

// ---- verilog/lce_cond_stack.sv ----
// Last-in first-out buffer of saved unused execution conditions.
`timescale 1ns/100ps
`include "lce_defs.svh"

module lce_cond_stack
    import lce_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    lce_stack_if.stack stk
);

    lce_stk_type s_ff;
    lce_stk_type nxt_s;
    logic [`LCE_STK_IDX_W-1:0] topIdx;

    // Clear wins; a push into a full buffer or a pop from an empty one is
    // dropped here, the core reports it.
    always_comb
    begin
        nxt_s = s_ff;
        if (stk.clear)
        begin
            nxt_s.cnt = '0;
        end
        else if (stk.push && !stk.full)
        begin
            nxt_s.mem[s_ff.cnt[`LCE_STK_IDX_W-1:0]] = stk.pushBit; // RULE_10
            nxt_s.cnt = s_ff.cnt + 4'h1;
        end
        else if (stk.pop && !stk.empty)
        begin
            nxt_s.cnt = s_ff.cnt - 4'h1; // RULE_11
        end
    end

    // State register.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    // The newest entry sits just below the count.
    assign topIdx = s_ff.cnt[`LCE_STK_IDX_W-1:0] - 3'h1;
    assign stk.topBit = stk.empty ? 1'b0 : s_ff.mem[topIdx]; // RULE_11
    assign stk.empty = (s_ff.cnt == 4'h0);
    assign stk.full = (s_ff.cnt == `LCE_STK_FULL);

    property p_stk_lifo;
        @(posedge mclk) disable iff (rst)
        stk.push && !stk.full && !stk.clear |=> stk.topBit == $past(stk.pushBit);
    endproperty
    a_stk_lifo: assert property (p_stk_lifo) else $error("Top not last pushed."); // RULE_11

    property p_stk_depth;
        @(posedge mclk) disable iff (rst)
        s_ff.cnt == 4'h7 && stk.push && !stk.clear |=> !stk.empty && stk.full;
    endproperty
    a_stk_depth: assert property (p_stk_depth) else $error("Eighth entry lost."); // RULE_10

endmodule

// ---- verilog/lce_defs.svh ----
// Constants for the ladder condition evaluator: fields, sizes and depths.
`ifndef LCE_DEFS_SVH
`define LCE_DEFS_SVH

// Program memory address width and the last program address.
`define LCE_PA_W 10
`define LCE_LAST_ADDR 10'h3ff

// Instruction word layout: opcode on top, bit operand address below.
`define LCE_INSTR_W 20
`define LCE_OP_MSB 19
`define LCE_OP_LSB 16
`define LCE_BA_W 16

// Saved-condition buffer: eight entries, count reaches the depth itself.
`define LCE_STK_DEPTH 8
`define LCE_STK_IDX_W 3
`define LCE_STK_CNT_W 4
`define LCE_STK_FULL 4'h8

`endif

// ---- verilog/lce_evaluator.sv ----
// Ladder condition evaluator: scans program memory, evaluates bit logic.
`timescale 1ns/100ps
`include "lce_defs.svh"

// Overview of operation
// RULE_01 - Execute from address zero to first end instruction, then restart scan.
// RULE_02 - Nothing after the first end instruction is ever executed.
// RULE_03 - With no end instruction in memory the program never runs.
// RULE_04 - End has no operand and acts unconditionally.
// RULE_05 - Mid-line load pushes the current condition, then starts anew.
// RULE_06 - Only a mid-line load saves a condition; first load just replaces.
// RULE_07 - And-block-combine pops newest saved value and ANDs it in.
// RULE_08 - Or-block-combine pops newest saved value and ORs it in.
// RULE_09 - Block combines take no operand, only prior conditions.
// RULE_10 - Buffer holds eight blocks, at least seven pending combines.
// RULE_11 - Buffer is last-in first-out.
// RULE_12 - Immediate combines allow unlimited blocks; buffer stays one deep.
// RULE_13 - Incremental and deferred combining give identical results.
// RULE_14 - Programs keep eight or fewer blocks pending.
// RULE_15 - First load sets condition to operand bit, inverted load to inverse.
// RULE_16 - And instructions AND the condition with the bit or its inverse.
// RULE_17 - Or instructions OR the condition with the bit or its inverse.
// RULE_18 - Output writes the condition to its bit, inverted output complement.
// RULE_19 - Flag error on combine with empty buffer or push beyond depth.

module lce_evaluator
    import lce_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic progReload,
    output logic [`LCE_PA_W-1:0] progAddr,
    output logic progRdEn,
    input wire logic [`LCE_INSTR_W-1:0] progData,
    output logic [`LCE_BA_W-1:0] bitAddr,
    output logic bitRdEn,
    input wire logic bitRdData,
    output logic bitWrEn,
    output logic bitWrData,
    output logic execCond,
    output logic scanDone,
    output logic running,
    output logic noEndError,
    output logic underflowError,
    output logic overflowError
);

    // ****************************************************************
    // State and buffer
    // ****************************************************************

    lce_core_type s_ff;
    lce_core_type nxt_s;
    lce_op_type progOp;
    logic opBit;
    logic isLoad;
    logic isBlk;

    lce_stack_if stk ();

    lce_cond_stack u_stack (
        .mclk (mclk),
        .rst (rst),
        .stk (stk)
    );

    assign progOp = lce_op_type'(progData[`LCE_OP_MSB:`LCE_OP_LSB]);

    // Operand bit as the instruction sees it; inverted forms have odd-even
    // pairing in the opcode map, so the inverse is picked per opcode.
    always_comb
    begin
        case (s_ff.op)
            OP_LOAD_INV, OP_AND_INV, OP_OR_INV: opBit = ~bitRdData;
            default: opBit = bitRdData;
        endcase
    end

    assign isLoad = (s_ff.op == OP_LOAD) || (s_ff.op == OP_LOAD_INV);
    assign isBlk = (progOp == OP_AND_BLK) || (progOp == OP_OR_BLK);

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    // Program memory reads return one cycle after the address, so every fetch
    // costs a wait state (operand bits return in the same cycle); slow but needs no prefetch logic.
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.bitRdEn = 1'b0;
        nxt_s.bitWrEn = 1'b0;
        nxt_s.scanDone = 1'b0;
        stk.push = 1'b0;
        stk.pop = 1'b0;
        stk.clear = 1'b0;
        stk.pushBit = s_ff.cond;
        case (s_ff.st)
            ST_SEARCH:
            begin
                nxt_s.st = ST_SCHK;
            end
            ST_SCHK:
            begin
                if (progOp == OP_END)
                begin
                    nxt_s.pc = '0;
                    nxt_s.lineStart = 1'b1;
                    nxt_s.running = 1'b1;
                    nxt_s.st = ST_FETCH;
                end
                else if (s_ff.pc == `LCE_LAST_ADDR)
                begin
                    nxt_s.noEnd = 1'b1; // RULE_03
                    nxt_s.st = ST_NOEND;
                end
                else
                begin
                    nxt_s.pc = s_ff.pc + 10'h1;
                    nxt_s.st = ST_SEARCH;
                end
            end
            ST_FETCH:
            begin
                nxt_s.st = ST_DECODE;
            end
            ST_DECODE:
            begin
                nxt_s.op = progOp;
                nxt_s.pc = s_ff.pc + 10'h1;
                nxt_s.st = ST_FETCH;
                case (progOp)
                    OP_LOAD, OP_LOAD_INV, OP_AND, OP_AND_INV, OP_OR,
                    OP_OR_INV:
                    begin
                        nxt_s.bitAddr = progData[`LCE_BA_W-1:0];
                        nxt_s.bitRdEn = 1'b1;
                        nxt_s.st = ST_EXEC;
                    end
                    OP_AND_BLK, OP_OR_BLK:
                    begin
                        // No operand field is read for combines. RULE_09
                        if (stk.empty)
                            nxt_s.underflow = 1'b1; // RULE_19
                        else
                        begin
                            stk.pop = 1'b1; // RULE_11
                            if (progOp == OP_AND_BLK)
                                nxt_s.cond = s_ff.cond & stk.topBit; // RULE_07
                            else
                                nxt_s.cond = s_ff.cond | stk.topBit; // RULE_08
                        end
                    end
                    OP_OUT, OP_OUT_INV:
                    begin
                        nxt_s.bitAddr = progData[`LCE_BA_W-1:0];
                        nxt_s.bitWrEn = 1'b1;
                        nxt_s.bitWrData = s_ff.cond ^ (progOp == OP_OUT_INV); // RULE_18
                        nxt_s.lineStart = 1'b1;
                    end
                    OP_END:
                    begin
                        // Unconditional: the condition is not consulted. RULE_04
                        nxt_s.pc = '0; // RULE_01 RULE_02
                        nxt_s.lineStart = 1'b1;
                        nxt_s.scanDone = 1'b1;
                        stk.clear = 1'b1;
                    end
                    default:
                    begin
                        nxt_s.st = ST_FETCH;
                    end
                endcase
            end
            ST_EXEC:
            begin
                nxt_s.st = ST_FETCH;
                if (isLoad)
                begin
                    if (!s_ff.lineStart)
                    begin
                        if (stk.full)
                            nxt_s.overflow = 1'b1; // RULE_19
                        else
                            stk.push = 1'b1; // RULE_05 RULE_12 RULE_13
                    end
                    nxt_s.cond = opBit; // RULE_06 RULE_15
                    nxt_s.lineStart = 1'b0;
                end
                else if (s_ff.op == OP_AND || s_ff.op == OP_AND_INV)
                    nxt_s.cond = s_ff.cond & opBit; // RULE_16
                else
                    nxt_s.cond = s_ff.cond | opBit; // RULE_17
            end
            ST_NOEND:
            begin
                nxt_s.st = ST_NOEND;
            end
            default:
            begin
                nxt_s.st = ST_SEARCH;
            end
        endcase
        // A changed program is searched again for its first end instruction.
        if (progReload)
        begin
            nxt_s = '0;
            stk.push = 1'b0;
            stk.pop = 1'b0;
            stk.clear = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Program read strobe is combinational; all data outputs are flops.
    assign progAddr = s_ff.pc;
    assign progRdEn = (s_ff.st == ST_SEARCH) || (s_ff.st == ST_FETCH);
    assign bitAddr = s_ff.bitAddr;
    assign bitRdEn = s_ff.bitRdEn;
    assign bitWrEn = s_ff.bitWrEn;
    assign bitWrData = s_ff.bitWrData;
    assign execCond = s_ff.cond;
    assign scanDone = s_ff.scanDone;
    assign running = s_ff.running;
    assign noEndError = s_ff.noEnd;
    assign underflowError = s_ff.underflow;
    assign overflowError = s_ff.overflow;

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_end_restart;
        s_ff.st == ST_DECODE && progOp == OP_END && !progReload
            |=> scanDone && progRdEn && progAddr == '0;
    endproperty
    a_end_restart: assert property (p_end_restart) else $error("No restart."); // RULE_01

    property p_scan_done;
        scanDone |-> s_ff.st == ST_FETCH && progAddr == '0 && stk.empty;
    endproperty
    a_scan_done: assert property (p_scan_done) else $error("Bad scan end."); // RULE_02

    property p_noend_idle;
        noEndError && !progReload |=> !bitWrEn && !progRdEn && noEndError;
    endproperty
    a_noend_idle: assert property (p_noend_idle) else $error("Ran with no end."); // RULE_03

    property p_mid_push;
        s_ff.st == ST_EXEC && isLoad && !s_ff.lineStart && !stk.full
            && !progReload |-> stk.push && stk.pushBit == execCond;
    endproperty
    a_mid_push: assert property (p_mid_push) else $error("Mid-line not saved."); // RULE_05

    property p_first_load;
        s_ff.st == ST_EXEC && isLoad && s_ff.lineStart && !progReload
            |-> !stk.push ##1 execCond == $past(opBit);
    endproperty
    a_first_load: assert property (p_first_load) else $error("First load wrong."); // RULE_06

    property p_and_blk;
        s_ff.st == ST_DECODE && progOp == OP_AND_BLK && !stk.empty
            && !progReload |=> execCond == ($past(execCond) & $past(stk.topBit));
    endproperty
    a_and_blk: assert property (p_and_blk) else $error("AND combine wrong."); // RULE_07

    property p_or_blk;
        s_ff.st == ST_DECODE && progOp == OP_OR_BLK && !stk.empty
            && !progReload |=> execCond == ($past(execCond) | $past(stk.topBit));
    endproperty
    a_or_blk: assert property (p_or_blk) else $error("OR combine wrong."); // RULE_08

    property p_out;
        s_ff.st == ST_DECODE && progOp == OP_OUT_INV && !progReload
            |=> bitWrEn && bitWrData == !$past(execCond);
    endproperty
    a_out: assert property (p_out) else $error("Inverted output wrong."); // RULE_18

    property p_underflow;
        s_ff.st == ST_DECODE && isBlk && stk.empty && !progReload
            |=> underflowError && $stable(execCond);
    endproperty
    a_underflow: assert property (p_underflow) else $error("Underflow missed."); // RULE_19

endmodule

// ---- verilog/lce_pkg.sv ----
// Types shared by the ladder condition evaluator modules.
`include "lce_defs.svh"

package lce_pkg;

    // Instruction opcodes held in the top field of a program word.
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_LOAD = 4'h1,
        OP_LOAD_INV = 4'h2,
        OP_AND = 4'h3,
        OP_AND_INV = 4'h4,
        OP_OR = 4'h5,
        OP_OR_INV = 4'h6,
        OP_AND_BLK = 4'h7,
        OP_OR_BLK = 4'h8,
        OP_OUT = 4'h9,
        OP_OUT_INV = 4'ha,
        OP_END = 4'hf
    } lce_op_type;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_SEARCH = 3'b000,
        ST_SCHK = 3'b001,
        ST_FETCH = 3'b010,
        ST_DECODE = 3'b011,
        ST_EXEC = 3'b100,
        ST_NOEND = 3'b101
    } lce_state_type;

    // Whole state of the evaluator core.
    typedef struct packed {
        lce_state_type st;
        logic [`LCE_PA_W-1:0] pc;
        lce_op_type op;
        logic cond;
        logic lineStart;
        logic [`LCE_BA_W-1:0] bitAddr;
        logic bitRdEn;
        logic bitWrEn;
        logic bitWrData;
        logic scanDone;
        logic running;
        logic noEnd;
        logic underflow;
        logic overflow;
    } lce_core_type;

    // Whole state of the saved-condition buffer.
    typedef struct packed {
        logic [`LCE_STK_DEPTH-1:0] mem;
        logic [`LCE_STK_CNT_W-1:0] cnt;
    } lce_stk_type;

endpackage

// ---- verilog/lce_stack_if.sv ----
// Carrier between the evaluator core and its saved-condition buffer.
`timescale 1ns/100ps

interface lce_stack_if;
    logic push;
    logic pop;
    logic clear;
    logic pushBit;
    logic topBit;
    logic empty;
    logic full;

    modport core (
        output push,
        output pop,
        output clear,
        output pushBit,
        input topBit,
        input empty,
        input full
    );

    modport stack (
        input push,
        input pop,
        input clear,
        input pushBit,
        output topBit,
        output empty,
        output full
    );
endinterface
